// file: core/pin_edge_sync.sv
// Three-stage pin synchroniser with agreed-level edge detection.
module pin_edge_sync (
  input  wire logic clk,   // Timer clock
  input  wire logic rstn,  // Async reset, active low
  input  wire logic pin,   // Asynchronous pin level
  output logic      rise,  // One-cycle pulse on accepted rising edge
  output logic      fall   // One-cycle pulse on accepted falling edge
);
  logic [2:0] sync_q;
  logic [2:0] sync_d;
  logic       level_q;
  logic       level_d;

  // Shift chain; stage 0 is read only by stage 1
  always_comb begin
    sync_d  = {sync_q[1:0], pin};
    level_d = (sync_q[1] == sync_q[2]) ? sync_q[2] : level_q;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync_q  <= 3'h0;
      level_q <= 1'b0;
    end else begin
      sync_q  <= sync_d;
      level_q <= level_d;
    end
  end

  // Edge counts once stages 1 and 2 agree, so a pin edge gives one event
  assign rise = level_d & ~level_q;
  assign fall = ~level_d & level_q;
endmodule

// file: core/timer_consts.svh
// Constants for the six-module timer block: sizes, field codes and counts.
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH

// ----------------------------------------------------------------------------
// Sizes
// ----------------------------------------------------------------------------
`define TM_COUNT        6
`define TM_PERIODIC_CNT 5
`define TM_STD_INDEX    0
`define TM_CNT_W        16
`define TM_RP_STD_W     8
`define TM_PRE_W        6

// ----------------------------------------------------------------------------
// Clock select codes (clock_select_field)
// ----------------------------------------------------------------------------
`define CKS_SYS_DIV4    3'h0
`define CKS_SYS         3'h1
`define CKS_HIGH_DIV16  3'h2
`define CKS_HIGH_DIV64  3'h3
`define CKS_SUB_A       3'h4
`define CKS_SUB_B       3'h5
`define CKS_EXT_RISE    3'h6
`define CKS_EXT_FALL    3'h7

// Prescaler masks: a tick when the masked prescaler bits are all zero
`define PRE_MASK_DIV4   6'h03
`define PRE_MASK_DIV16  6'h0f
`define PRE_MASK_DIV64  6'h3f

// ----------------------------------------------------------------------------
// Operating mode codes
// ----------------------------------------------------------------------------
`define MODE_COMPARE    2'h0
`define MODE_CAPTURE    2'h1
`define MODE_PWM        2'h2
`define MODE_TIMER      2'h3

// ----------------------------------------------------------------------------
// Pin function codes (pin_function_field)
// ----------------------------------------------------------------------------
`define PF_NONE         2'h0
`define PF_LOW          2'h1
`define PF_HIGH         2'h2
`define PF_TOGGLE       2'h3
`define PF_PWM_INACT    2'h0
`define PF_PWM_ACT      2'h1
`define PF_PWM_OUT      2'h2
`define PF_SINGLE       2'h3
`define PF_CAP_RISE     2'h0
`define PF_CAP_FALL     2'h1
`define PF_CAP_BOTH     2'h2
`define PF_CAP_OFF      2'h3

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CNT_RESET       16'h0000
`define PRE_RESET       6'h00

`endif

// file: core/timer_modules.sv
// Six timer modules: one standard type and five periodic types.
// Index 0 of every port array is the standard timer; index n+1 is
// periodic timer n.
`include "timer_consts.svh"
module timer_modules (
  input  wire logic                                clk,             // 10 MHz system clock
  input  wire logic                                rstn,            // Async reset, active low
  input  wire logic                                sub_clock_tick,  // Sub clock pulse, same domain
  input  wire logic [`TM_COUNT-1:0]                counter_on,      // Counter-on bit per timer
  input  wire logic [`TM_COUNT-1:0]                pause,           // Counter pause per timer
  input  wire timer_pkg::clk_sel_t [`TM_COUNT-1:0] clock_select,    // Clock select field
  input  wire timer_pkg::mode_t [`TM_COUNT-1:0]    mode,            // Operating mode
  input  wire timer_pkg::pin_fn_t [`TM_COUNT-1:0]  pin_function,    // Pin function field
  input  wire logic [`TM_COUNT-1:0]                out_init,        // Output initial level
  input  wire logic [`TM_COUNT-1:0]                out_invert,      // Output polarity invert
  input  wire logic [`TM_COUNT-1:0]                duty_from_p,     // PWM: 1 = P sets duty
  input  wire logic [`TM_COUNT-1:0]                clear_on_a,      // Clear on A (1) or P (0)
  input  wire logic [`TM_COUNT-1:0]                cap_from_clk,    // Capture from clock pin
  input  wire timer_pkg::count_t [`TM_COUNT-1:0]   compare_a,       // Comparator A value
  input  wire timer_pkg::count_t [`TM_COUNT-1:0]   compare_p,       // Comparator P value
  input  wire logic [`TM_COUNT-1:0]                flag_a_clr,      // Clear A flag, pulse
  input  wire logic [`TM_COUNT-1:0]                flag_p_clr,      // Clear P flag, pulse
  input  wire logic [`TM_COUNT-1:0]                in_pin_sel,      // Input pins select timer
  input  wire logic [`TM_COUNT-1:0]                out_pin_sel,     // Output pin selects timer
  input  wire logic [`TM_COUNT-1:0]                timer_ext_clock_pin, // External clock pins
  input  wire logic [`TM_COUNT-1:0]                timer_capture_pin,   // Capture input pins
  output timer_pkg::count_t [`TM_COUNT-1:0]        count_value,     // Counter value
  output timer_pkg::count_t [`TM_COUNT-1:0]        capture_value,   // Last captured count
  output logic [`TM_COUNT-1:0]                     flag_a,          // Comparator A interrupt
  output logic [`TM_COUNT-1:0]                     flag_p,          // Comparator P interrupt
  output logic [`TM_COUNT-1:0]                     timer_output_pin, // Output pin level
  output logic [`TM_COUNT-1:0]                     timer_output_oe   // Output pin drive enable
);
  import timer_pkg::*;

  // --------------------------------------------------------------------------
  // Shared prescaler
  // --------------------------------------------------------------------------
  pre_t pre_q;
  pre_t pre_d;

  // Free-running divider; fH is taken equal to the system clock here
  always_comb begin
    pre_d = pre_q + pre_t'(1);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pre_q <= `PRE_RESET;
    end else begin
      pre_q <= pre_d;
    end
  end

  // --------------------------------------------------------------------------
  // Per-timer logic
  // --------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < `TM_COUNT; gi++) begin : g_tm
      logic   ck_rise;
      logic   ck_fall;
      logic   cp_rise;
      logic   cp_fall;
      logic   tick;
      logic   match_a;
      logic   match_p;
      logic   on_rise;
      logic   cap_evt;
      logic   trig;
      logic   duty_hit;
      logic   period_hit;
      count_t cnt_q;
      count_t cnt_d;
      count_t cap_q;
      count_t cap_d;
      logic   fa_q;
      logic   fa_d;
      logic   fp_q;
      logic   fp_d;
      logic   on_q;
      logic   out_q;
      logic   out_d;
      logic   oe_q;
      logic   oe_d;
      logic   pulse_q;
      logic   pulse_d;

      // Synchronise both input pins
      pin_edge_sync u_ck_sync (
        .clk  (clk),
        .rstn (rstn),
        .pin  (timer_ext_clock_pin[gi]),
        .rise (ck_rise),
        .fall (ck_fall)
      );

      pin_edge_sync u_cp_sync (
        .clk  (clk),
        .rstn (rstn),
        .pin  (timer_capture_pin[gi]),
        .rise (cp_rise),
        .fall (cp_fall)
      );

      // Count tick from the selected source
      always_comb begin
        case (clock_select[gi])
          `CKS_SYS_DIV4:   tick = (pre_q & `PRE_MASK_DIV4) == `PRE_RESET;
          `CKS_SYS:        tick = 1'b1;
          `CKS_HIGH_DIV16: tick = (pre_q & `PRE_MASK_DIV16) == `PRE_RESET;
          `CKS_HIGH_DIV64: tick = (pre_q & `PRE_MASK_DIV64) == `PRE_RESET;
          `CKS_SUB_A:      tick = sub_clock_tick;
          `CKS_SUB_B:      tick = sub_clock_tick;
          `CKS_EXT_RISE:   tick = in_pin_sel[gi] & ck_rise;
          `CKS_EXT_FALL:   tick = in_pin_sel[gi] & ck_fall;
          default:         tick = 1'b0;
        endcase
      end

      // Comparators; the standard P comparator sees only the counter high byte
      always_comb begin
        if (gi == `TM_STD_INDEX) begin
          match_p = cnt_q[`TM_CNT_W-1 -: `TM_RP_STD_W] ==
                    compare_p[gi][`TM_RP_STD_W-1:0];
        end else begin
          match_p = cnt_q == compare_p[gi];
        end
        match_a = cnt_q == compare_a[gi];
      end

      // Events: counter-on rise, capture edge, single pulse trigger
      always_comb begin
        on_rise = counter_on[gi] & ~on_q;
        cap_evt = 1'b0;
        if (in_pin_sel[gi]) begin
          if ((gi != `TM_STD_INDEX) && cap_from_clk[gi]) begin
            case (pin_function[gi])
              `PF_CAP_RISE: cap_evt = ck_rise;
              `PF_CAP_FALL: cap_evt = ck_fall;
              `PF_CAP_BOTH: cap_evt = ck_rise | ck_fall;
              default:      cap_evt = 1'b0;
            endcase
          end else begin
            case (pin_function[gi])
              `PF_CAP_RISE: cap_evt = cp_rise;
              `PF_CAP_FALL: cap_evt = cp_fall;
              `PF_CAP_BOTH: cap_evt = cp_rise | cp_fall;
              default:      cap_evt = 1'b0;
            endcase
          end
        end
        trig = in_pin_sel[gi] & ck_rise;
      end

      // Counter: a counter-on rise or a clearing A or P match loads it, to zero
      always_comb begin
        cnt_d = cnt_q;
        if (on_rise) begin
          cnt_d = `CNT_RESET;
        end else if (counter_on[gi] && !pause[gi] && tick) begin
          if ((clear_on_a[gi] && match_a) || (!clear_on_a[gi] && match_p)) begin
            cnt_d = `CNT_RESET;
          end else begin
            cnt_d = cnt_q + count_t'(1);
          end
        end
      end

      // Capture register and sticky match flags; a new event beats a clear
      always_comb begin
        cap_d = cap_q;
        fa_d  = fa_q & ~flag_a_clr[gi];
        fp_d  = fp_q & ~flag_p_clr[gi];
        if (mode[gi] == `MODE_CAPTURE) begin
          if (counter_on[gi] && cap_evt) begin
            cap_d = cnt_q;
            fa_d  = 1'b1;
          end
        end else if (counter_on[gi] && tick && match_a) begin
          fa_d = 1'b1;
        end
        if (counter_on[gi] && tick && match_p) begin
          fp_d = 1'b1;
        end
      end

      // PWM: duty or period comes from one comparator, never both
      always_comb begin
        if (duty_from_p[gi]) begin
          duty_hit   = match_p;
          period_hit = match_a;
        end else begin
          duty_hit   = match_a;
          period_hit = match_p;
        end
      end

      // Output pin behaviour by mode; drive only when selected
      always_comb begin
        out_d   = out_q;
        pulse_d = pulse_q;
        oe_d    = out_pin_sel[gi] && (mode[gi] != `MODE_TIMER);
        if (on_rise) begin
          out_d   = out_init[gi];
          pulse_d = 1'b0;
        end else if (!counter_on[gi]) begin
          out_d = out_q;
        end else begin
          case (mode[gi])
            `MODE_COMPARE: begin
              if (tick && match_a) begin
                case (pin_function[gi])
                  `PF_LOW:    out_d = 1'b0 ^ out_invert[gi];
                  `PF_HIGH:   out_d = 1'b1 ^ out_invert[gi];
                  `PF_TOGGLE: out_d = ~out_q;
                  default:    out_d = out_q;
                endcase
              end
            end
            `MODE_PWM: begin
              case (pin_function[gi])
                `PF_PWM_INACT: out_d = out_invert[gi];
                `PF_PWM_ACT:   out_d = ~out_invert[gi];
                `PF_PWM_OUT: begin
                  // Active from period start until the duty match
                  if (tick && period_hit) begin
                    out_d = ~out_invert[gi];
                  end else if (tick && duty_hit) begin
                    out_d = out_invert[gi];
                  end
                end
                `PF_SINGLE: begin
                  // Pulse starts on pin trigger, ends on comparator A match
                  if (trig && !pulse_q) begin
                    pulse_d = 1'b1;
                    out_d   = ~out_invert[gi];
                  end else if (pulse_q && tick && match_a) begin
                    pulse_d = 1'b0;
                    out_d   = out_invert[gi];
                  end
                end
                default: out_d = out_q;
              endcase
            end
            default: out_d = out_q;
          endcase
        end
      end

      // State registers for this timer
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          cnt_q   <= `CNT_RESET;
          cap_q   <= `CNT_RESET;
          fa_q    <= 1'b0;
          fp_q    <= 1'b0;
          on_q    <= 1'b0;
          out_q   <= 1'b0;
          oe_q    <= 1'b0;
          pulse_q <= 1'b0;
        end else begin
          cnt_q   <= cnt_d;
          cap_q   <= cap_d;
          fa_q    <= fa_d;
          fp_q    <= fp_d;
          on_q    <= counter_on[gi];
          out_q   <= out_d;
          oe_q    <= oe_d;
          pulse_q <= pulse_d;
        end
      end

      // Every output is a flip-flop
      assign count_value[gi]      = cnt_q;
      assign capture_value[gi]    = cap_q;
      assign flag_a[gi]           = fa_q;
      assign flag_p[gi]           = fp_q;
      assign timer_output_pin[gi] = out_q;
      assign timer_output_oe[gi]  = oe_q;
    end
  endgenerate
endmodule

// file: core/timer_pkg.sv
// Types shared by the timer block files.
`include "timer_consts.svh"
package timer_pkg;
  typedef logic [`TM_CNT_W-1:0] count_t;
  typedef logic [2:0]           clk_sel_t;
  typedef logic [1:0]           mode_t;
  typedef logic [1:0]           pin_fn_t;
  typedef logic [`TM_PRE_W-1:0] pre_t;
endpackage

// file: tb/tb.sv
// Self-checking bench for the six-module timer block.
`include "timer_consts.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import timer_pkg::*;
  localparam int NT = `TM_COUNT;
  // Ticks in any 64 edges for internal clock codes 5..0; the sub tick runs every other cycle
  localparam count_t [5:0] TICKS_64 = {16'h0020, 16'h0020, 16'h0001, 16'h0004, 16'h0040,
                                       16'h0010};
  logic                clk, rstn;
  logic                tick = 1'b0;
  logic [NT-1:0]       counter_on, pause, out_init, out_invert, duty_from_p, clear_on_a;
  logic [NT-1:0]       cap_from_clk, flag_a_clr, flag_p_clr, in_pin_sel, out_pin_sel;
  logic [NT-1:0]       ext_pin, cap_pin, flag_a, flag_p, out_pin, out_oe;
  clk_sel_t [NT-1:0]   clock_select;
  mode_t [NT-1:0]      mode;
  pin_fn_t [NT-1:0]    pin_function;
  count_t [NT-1:0]     compare_a, compare_p, count_value, capture_value;
  int                  n_fail = 0;
  int                  n_tests = 0;
  int                  h0, h1;
  count_t              v;

  timer_modules dut_u (.clk(clk), .rstn(rstn), .sub_clock_tick(tick), .counter_on(counter_on),
    .pause(pause), .clock_select(clock_select), .mode(mode), .pin_function(pin_function),
    .out_init(out_init), .out_invert(out_invert), .duty_from_p(duty_from_p),
    .clear_on_a(clear_on_a), .cap_from_clk(cap_from_clk), .compare_a(compare_a),
    .compare_p(compare_p), .flag_a_clr(flag_a_clr), .flag_p_clr(flag_p_clr),
    .in_pin_sel(in_pin_sel), .out_pin_sel(out_pin_sel), .timer_ext_clock_pin(ext_pin),
    .timer_capture_pin(cap_pin), .count_value(count_value), .capture_value(capture_value),
    .flag_a(flag_a), .flag_p(flag_p), .timer_output_pin(out_pin), .timer_output_oe(out_oe));
  tm_pin_model pins_u (.clk(clk), .ext_pin(ext_pin), .cap_pin(cap_pin));

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic check(input count_t seen, input count_t exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Stop, clear both flags, configure, then restart with a fresh clear
  task automatic start(input int k, input clk_sel_t cs, input mode_t md, input pin_fn_t pf);
    @(posedge clk);
    counter_on[k] <= 1'b0;
    flag_a_clr[k] <= 1'b1;
    flag_p_clr[k] <= 1'b1;
    clock_select[k] <= cs;
    mode[k] <= md;
    pin_function[k] <= pf;
    @(posedge clk);
    flag_a_clr[k] <= 1'b0;
    flag_p_clr[k] <= 1'b0;
    counter_on[k] <= 1'b1;
    @(negedge clk);
    check(count_t'({flag_a[k], flag_p[k]}), 16'h0000);
  endtask
  // Bounded wait for flag A (0), flag P (1) or the output pin (2)
  task automatic wait_bit(input int sel, input int k);
    int i;
    for (i = 0; i < 300; i++) begin
      @(negedge clk);
      if ((sel == 0 ? flag_a[k] : sel == 1 ? flag_p[k] : out_pin[k]) === 1'b1) break;
    end
    check(count_t'(i < 300), 16'h0001);
  endtask
  task automatic pwm_highs(output int hi);
    hi = 0;
    repeat (40) begin
      @(negedge clk);
      hi += out_pin[5];
    end
  endtask

  // ----------------------------------------------------------------------
  // Clock, sub clock tick and watchdog
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) tick <= ~tick;
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    wrap_up();
  end

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    rstn = 1'b0; counter_on = '0; pause = '0; out_init = '0; out_invert = '0;
    duty_from_p = '0; clear_on_a = 6'h1b; cap_from_clk = '0; flag_a_clr = '0;
    flag_p_clr = '0; in_pin_sel = '1; out_pin_sel = '1; clock_select = {NT{`CKS_SYS}};
    mode = {NT{`MODE_COMPARE}}; pin_function = '0;
    compare_a = {NT{16'h0005}}; compare_p = {NT{16'h0009}};
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    @(negedge clk);
    check(count_value[1], `CNT_RESET);
    // Low, high and toggle on A match; standard timer takes the first
    for (int j = 1; j < 4; j++) begin
      @(posedge clk);
      out_init[j > 1] <= (j == 1);
      start(j > 1, `CKS_SYS, `MODE_COMPARE, pin_fn_t'(j));
      wait_bit(0, j > 1);
      check(count_value[j > 1], `CNT_RESET);
      check(count_t'(out_pin[j > 1]), count_t'(j != 1));
      check(count_t'(out_oe[j > 1]), 16'h0001);
    end
    // Pause holds the running count
    @(posedge clk);
    pause[1] <= 1'b1;
    repeat (2) @(negedge clk);
    v = count_value[1];
    repeat (5) @(negedge clk);
    check(count_value[1], v);
    // P match clears the counter; timer mode releases the pin
    start(2, `CKS_SYS, `MODE_TIMER, `PF_NONE);
    wait_bit(1, 2);
    check(count_value[2], `CNT_RESET);
    check(count_t'({flag_a[2], out_oe[2]}), 16'h0002);
    // External clock, both edges, then with the input pins deselected
    @(posedge clk);
    compare_a[3] <= 16'h0fff;
    compare_p[3] <= 16'h0fff;
    for (int j = 0; j < 3; j++) begin
      @(posedge clk);
      in_pin_sel[3] <= (j < 2);
      start(3, (j == 1) ? `CKS_EXT_FALL : `CKS_EXT_RISE, `MODE_TIMER, `PF_NONE);
      pins_u.pulse(3, 1'b0, 5);
      repeat (5) @(negedge clk);
      check(count_value[3], (j < 2) ? 16'h0005 : 16'h0000);
    end
    // Internal sources: 64 edges hold a fixed tick count, whatever the divider phase
    for (int j = 0; j < 6; j++) begin
      start(3, clk_sel_t'(j), `MODE_TIMER, `PF_NONE);
      repeat (65) @(negedge clk);
      check(count_value[3], TICKS_64[j]);
    end
    // Capture on every edge code, then from the clock pin
    @(posedge clk);
    compare_a[4] <= 16'h0fff;
    compare_p[4] <= 16'h0fff;
    for (int j = 0; j < 5; j++) begin
      @(posedge clk);
      cap_from_clk[4] <= (j == 4);
      start(4, `CKS_SYS, `MODE_CAPTURE, pin_fn_t'(j % 4));
      pins_u.pulse(4, j != 4, 1);
      repeat (5) @(negedge clk);
      check(count_t'(flag_a[4]), count_t'(j != 3));
      // A rise lands three counts after the restart, a fall four later; off keeps the last
      check(capture_value[4], (j == 0 || j == 4) ? 16'h0003 : 16'h0007);
    end
    // PWM with duty from A, then the same wave with the roles swapped
    start(5, `CKS_SYS, `MODE_PWM, `PF_PWM_OUT);
    pwm_highs(h0);
    @(posedge clk);
    duty_from_p[5] <= 1'b1;
    clear_on_a[5] <= 1'b1;
    compare_a[5] <= 16'h0009;
    compare_p[5] <= 16'h0005;
    start(5, `CKS_SYS, `MODE_PWM, `PF_PWM_OUT);
    pwm_highs(h1);
    // Active for counts 0 to 5 of each ten-count period after the first: three active periods in the window
    check(count_t'(h0), 16'h0012);
    check(count_t'(h1), 16'h0012);
    // Single pulse fired by the external clock pin
    start(5, `CKS_SYS, `MODE_PWM, `PF_SINGLE);
    fork
      pins_u.pulse(5, 1'b0, 1);
      wait_bit(2, 5);
    join
    // The pulse ends on the A match at count 9
    repeat (6) @(negedge clk);
    check(count_t'(out_pin[5]), 16'h0000);
    // Forced inactive and active levels on the same pin
    for (int j = 0; j < 2; j++) begin
      start(5, `CKS_SYS, `MODE_PWM, pin_fn_t'(j));
      repeat (3) @(negedge clk);
      check(count_t'(out_pin[5]), count_t'(j));
    end
    wrap_up();
  end
endmodule

// file: tb/timer_modules_assertions.sv
// Port checker for the timer block, bound to timer_modules.
`include "timer_consts.svh"
module timer_modules_chk (
  input wire logic                                clk,              // Timer clock
  input wire logic                                rstn,             // Async reset, active low
  input wire logic [`TM_COUNT-1:0]                counter_on,       // Counter-on bits
  input wire logic [`TM_COUNT-1:0]                pause,            // Pause bits
  input wire timer_pkg::clk_sel_t [`TM_COUNT-1:0] clock_select,     // Clock selects
  input wire timer_pkg::mode_t [`TM_COUNT-1:0]    mode,             // Modes
  input wire timer_pkg::pin_fn_t [`TM_COUNT-1:0]  pin_function,     // Pin functions
  input wire logic [`TM_COUNT-1:0]                out_invert,       // Output polarity
  input wire logic [`TM_COUNT-1:0]                flag_a_clr,       // A flag clear
  input wire logic [`TM_COUNT-1:0]                flag_p_clr,       // P flag clear
  input wire logic [`TM_COUNT-1:0]                out_pin_sel,      // Output pin select
  input wire timer_pkg::count_t [`TM_COUNT-1:0]   compare_a,        // Comparator A
  input wire timer_pkg::count_t [`TM_COUNT-1:0]   compare_p,        // Comparator P
  input wire timer_pkg::count_t [`TM_COUNT-1:0]   count_value,      // Counters
  input wire logic [`TM_COUNT-1:0]                flag_a,           // A flags
  input wire logic [`TM_COUNT-1:0]                flag_p,           // P flags
  input wire logic [`TM_COUNT-1:0]                timer_output_pin, // Output levels
  input wire logic [`TM_COUNT-1:0]                timer_output_oe   // Output enables
);
  timeunit 1ns;
  timeprecision 1ns;
  import timer_pkg::*;
  logic [`TM_COUNT-1:0] on_q; // Counter-on one cycle late
  logic [`TM_COUNT-1:0] run;  // Ticking each cycle, not a fresh start
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // A fresh start clears the count, so it is kept out of the counting relations
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      on_q <= '0;
    end else begin
      on_q <= counter_on;
    end
  end
  for (genvar i = 0; i < `TM_COUNT; i++) begin : g_tm
    assign run[i] = counter_on[i] & on_q[i] & ~pause[i] & (clock_select[i] == `CKS_SYS);
    AST_START_CLEAR: assert property ($rose(counter_on[i]) |=> count_value[i] == `CNT_RESET)
      else $error("count not cleared by counter start");
    AST_HOLD_OFF: assert property (!counter_on[i] |=> $stable(count_value[i]))
      else $error("count moved while counter off");
    AST_A_FLAG: assert property (run[i] && mode[i] == `MODE_COMPARE
      && count_value[i] == compare_a[i] |=> flag_a[i])
      else $error("A match raised no flag");
    AST_A_STICKY: assert property (flag_a[i] && !flag_a_clr[i] |=> flag_a[i])
      else $error("A flag dropped without clear");
    AST_P_CLEAR: assert property (flag_p[i] && flag_p_clr[i] && !counter_on[i] |=> !flag_p[i])
      else $error("P flag survived its clear");
    AST_OE_ON: assert property (out_pin_sel[i] && mode[i] != `MODE_TIMER |=> timer_output_oe[i])
      else $error("output not driven when selected");
    AST_OE_OFF: assert property (!out_pin_sel[i] |=> !timer_output_oe[i])
      else $error("output driven while not selected");
    AST_CMP_HIGH: assert property (run[i] && mode[i] == `MODE_COMPARE && !out_invert[i]
      && pin_function[i] == `PF_HIGH && count_value[i] == compare_a[i] |=> timer_output_pin[i])
      else $error("compare high left pin low");
    if (i > 0) begin : g_up
      AST_COUNT_UP: assert property (run[i] && (mode[i] == `MODE_COMPARE || mode[i] == `MODE_TIMER)
        && count_value[i] != compare_a[i] && count_value[i] != compare_p[i]
        && count_value[i] != 16'hffff |=> count_value[i] == $past(count_value[i]) + 16'h0001)
        else $error("counter did not step by one");
    end
  end
endmodule

bind timer_modules timer_modules_chk chk_u (.clk(clk), .rstn(rstn), .counter_on(counter_on),
  .pause(pause), .clock_select(clock_select), .mode(mode), .pin_function(pin_function),
  .out_invert(out_invert), .flag_a_clr(flag_a_clr), .flag_p_clr(flag_p_clr),
  .out_pin_sel(out_pin_sel), .compare_a(compare_a), .compare_p(compare_p),
  .count_value(count_value), .flag_a(flag_a), .flag_p(flag_p),
  .timer_output_pin(timer_output_pin), .timer_output_oe(timer_output_oe));

// file: tb/tm_pin_model.sv
// External pin model: clean pulses on the timer clock and capture pins.
`include "timer_consts.svh"
module tm_pin_model (
  input  wire logic             clk,     // Timer clock
  output logic [`TM_COUNT-1:0]  ext_pin, // External clock pins
  output logic [`TM_COUNT-1:0]  cap_pin  // Capture input pins
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    ext_pin = '0;
    cap_pin = '0;
  end
  // Each level is held four cycles so the synchroniser accepts it
  task automatic pulse(input int k, input bit on_cap, input int n);
    repeat (n) begin
      @(posedge clk);
      if (on_cap) cap_pin[k] <= 1'b1; else ext_pin[k] <= 1'b1;
      repeat (4) @(posedge clk);
      if (on_cap) cap_pin[k] <= 1'b0; else ext_pin[k] <= 1'b0;
      repeat (3) @(posedge clk);
    end
  endtask
endmodule
